// >>> core/fles_pkg.sv
// Constants, register map and command codes for the erase sequencer host.
package fles_pkg;
    // Clock period of i_mclk in nanoseconds.
    localparam int CLK_NS = 8;
    // Least write-strobe low and high times, and read access time.
    localparam int WP_NS  = 35;
    localparam int WPH_NS = 30;
    localparam int RD_NS  = 70;
    // Least hardware reset pulse width.
    localparam int RST_NS = 500;
    // Sector collection window; the host must stay below it, so round down.
    localparam int WIN_US = 50;
    localparam int WP_CYC  = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC = (WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_CYC  = (RD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_CYC = (RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int WIN_CYC = (WIN_US * 1000) / CLK_NS;
    // Depth of the pin synchroniser on the data lines.
    localparam int SYNC_N  = 2;
    localparam int WIN_W   = 16;
    localparam int CNT_W   = 8;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;
    // Operation codes written into the low bits of the control register.
    localparam logic [2:0] OP_CHIP = 3'h1;
    localparam logic [2:0] OP_SECT = 3'h2;
    localparam logic [2:0] OP_ADD  = 3'h3;
    localparam logic [2:0] OP_SUS  = 3'h4;
    localparam logic [2:0] OP_RES  = 3'h5;
    localparam logic [2:0] OP_READ = 3'h6;
    localparam logic [2:0] OP_RST  = 3'h7;
    // Status register bit positions.
    localparam int STAT_BUSY   = 0;
    localparam int STAT_ERR    = 1;
    localparam int STAT_WIN    = 2;
    localparam int STAT_SUS    = 3;
    localparam int STAT_RD_LSB = 16;
    // Flash bus addresses and data codes of the command cycles.
    localparam logic [21:0] UNLK_A1 = 22'h00_0555;
    localparam logic [21:0] UNLK_A2 = 22'h00_02aa;
    localparam logic [21:0] ANY_A   = 22'h00_0000;
    localparam logic [15:0] CD_UNLK1 = 16'h00aa;
    localparam logic [15:0] CD_UNLK2 = 16'h0055;
    localparam logic [15:0] CD_SETUP = 16'h0080;
    localparam logic [15:0] CD_CHIP  = 16'h0010;
    localparam logic [15:0] CD_SECT  = 16'h0030;
    localparam logic [15:0] CD_SUS   = 16'h00b0;
    localparam logic [15:0] CD_RES   = 16'h0030;
    // Index of the final cycle of a six-cycle erase sequence.
    localparam logic [2:0] LAST_STEP = 3'h5;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // Sequencer states.
    typedef enum logic [2:0] {S_IDLE, S_WSU, S_WLO, S_WHI, S_RLO, S_RST}
        fles_state_t;
endpackage

// >>> core/fles_host.sv
// Host-side erase sequencer driving a parallel NOR flash, AXI4-Lite control.
`timescale 1ns/10ps
module fles_host
    import fles_pkg::*;
#(
    parameter logic [WIN_W-1:0] P_WIN_CYC = WIN_W'(WIN_CYC)
) (
    input  wire logic        i_mclk,
    input  wire logic        i_sys_rst,
    input  wire logic [3:0]  i_axi_awaddr,
    input  wire logic        i_axi_awvalid,
    output logic             o_axi_awready,
    input  wire logic [31:0] i_axi_wdata,
    input  wire logic [3:0]  i_axi_wstrb,
    input  wire logic        i_axi_wvalid,
    output logic             o_axi_wready,
    output logic [1:0]       o_axi_bresp,
    output logic             o_axi_bvalid,
    input  wire logic        i_axi_bready,
    input  wire logic [3:0]  i_axi_araddr,
    input  wire logic        i_axi_arvalid,
    output logic             o_axi_arready,
    output logic [31:0]      o_axi_rdata,
    output logic [1:0]       o_axi_rresp,
    output logic             o_axi_rvalid,
    input  wire logic        i_axi_rready,
    output logic [21:0]      o_fl_addr,
    output logic [15:0]      o_fl_dq,
    output logic             o_fl_dq_oe,
    input  wire logic [15:0] i_fl_dq,
    output logic             o_fl_ce_n,
    output logic             o_fl_oe_n,
    output logic             o_fl_we_n,
    output logic             o_fl_rst_n
);
    // Bus-side state: held address and data of a pending write, response.
    logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
    logic [3:0]  awa_q, awa_d, ws_q, ws_d;
    logic [31:0] wd_q, wd_d, rd_bus_q, rd_bus_d;
    logic [1:0]  br_q, br_d, rr_q, rr_d;
    // Software-visible control state.
    logic [31:0] addr_q, addr_d;
    logic        err_q, err_d, sus_q, sus_d;
    logic [WIN_W-1:0] win_q, win_d;
    // Sequencer state.
    fles_state_t st_q, st_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [2:0]  step_q, step_d, op_q, op_d;
    logic [15:0] rd_q, rd_d;
    // Registered pin values.
    logic [21:0] pa_q, pa_d;
    logic [15:0] pd_q, pd_d;
    logic        poe_q, poe_d, ce_q, ce_d, oe_q, oe_d, we_q, we_d;
    logic        rst_q, rst_d;
    // Data-line synchroniser; only the second stage is read by logic.
    logic [15:0] dqs1_q, dqs2_q;
    // Command decode terms.
    logic        wr_fire, cmd_go, busy, accept, refuse;
    logic [2:0]  cmd_op;
    logic [21:0] seq_a;
    logic [15:0] seq_d;

    // Handshake outputs come straight from the holding flags.
    assign o_axi_awready = !aw_q && !bv_q;
    assign o_axi_wready  = !w_q && !bv_q;
    assign o_axi_bvalid  = bv_q;
    assign o_axi_bresp   = br_q;
    assign o_axi_arready = !rv_q;
    assign o_axi_rvalid  = rv_q;
    assign o_axi_rresp   = rr_q;
    assign o_axi_rdata   = rd_bus_q;
    assign o_fl_addr  = pa_q;
    assign o_fl_dq    = pd_q;
    assign o_fl_dq_oe = poe_q;
    assign o_fl_ce_n  = ce_q;
    assign o_fl_oe_n  = oe_q;
    assign o_fl_we_n  = we_q;
    assign o_fl_rst_n = rst_q;

    // A write is performed once both its address and its data are held.
    assign wr_fire = aw_q && w_q && !bv_q;
    assign cmd_go  = wr_fire && (awa_q == REG_CTRL) && ws_q[0];
    assign cmd_op  = wd_q[2:0];
    assign busy    = (st_q != S_IDLE);
    // Late additions are refused here rather than risk a lost sector.
    assign accept = cmd_go && !busy && (cmd_op != 3'h0)
                    && ((cmd_op != OP_ADD) || (win_q != '0));
    assign refuse = cmd_go && !accept;

    // Address and data of the current command cycle.
    always_comb begin
        seq_a = UNLK_A1;
        seq_d = CD_UNLK1;
        unique case (step_q)
            3'h1, 3'h4: begin
                seq_a = UNLK_A2;    // Second unlock cycle.
                seq_d = CD_UNLK2;
            end
            3'h2: seq_d = CD_SETUP; // Erase set-up cycle.
            3'h5: begin
                unique case (op_q)
                    OP_CHIP: seq_d = CD_CHIP;
                    OP_SECT, OP_ADD: begin
                        seq_a = addr_q[21:0];
                        seq_d = CD_SECT;
                    end
                    OP_SUS: begin
                        seq_a = ANY_A;
                        seq_d = CD_SUS;
                    end
                    default: begin
                        seq_a = ANY_A;
                        seq_d = CD_RES;
                    end
                endcase
            end
            default: ;              // Steps 0 and 3 are the first unlock.
        endcase
    end

    // Bus slave next state: capture, register writes, responses, reads.
    always_comb begin
        aw_d = aw_q;
        awa_d = awa_q;
        w_d = w_q;
        wd_d = wd_q;
        ws_d = ws_q;
        bv_d = bv_q;
        br_d = br_q;
        rv_d = rv_q;
        rr_d = rr_q;
        rd_bus_d = rd_bus_q;
        addr_d = addr_q;
        if (i_axi_awvalid && o_axi_awready) begin
            aw_d = 1'b1;
            awa_d = i_axi_awaddr;
        end
        if (i_axi_wvalid && o_axi_wready) begin
            w_d = 1'b1;
            wd_d = i_axi_wdata;
            ws_d = i_axi_wstrb;
        end
        if (wr_fire) begin
            aw_d = 1'b0;
            w_d = 1'b0;
            bv_d = 1'b1;
            br_d = (awa_q == REG_CTRL || awa_q == REG_ADDR
                    || awa_q == REG_STAT) ? RESP_OK : RESP_ERR;
            // The sector address honours byte strobes.
            if (awa_q == REG_ADDR) begin
                for (int b = 0; b < 4; b++) begin
                    if (ws_q[b]) begin
                        addr_d[8*b +: 8] = wd_q[8*b +: 8];
                    end
                end
            end
        end
        if (bv_q && i_axi_bready) begin
            bv_d = 1'b0;
        end
        if (i_axi_arvalid && o_axi_arready) begin
            rv_d = 1'b1;
            rr_d = RESP_OK;
            rd_bus_d = '0;
            unique case (i_axi_araddr)
                REG_CTRL: rd_bus_d[2:0] = op_q;
                REG_ADDR: rd_bus_d = addr_q;
                REG_STAT: begin
                    rd_bus_d[STAT_BUSY] = busy;
                    rd_bus_d[STAT_ERR] = err_q;
                    rd_bus_d[STAT_WIN] = (win_q != '0);
                    rd_bus_d[STAT_SUS] = sus_q;
                    rd_bus_d[STAT_RD_LSB +: 16] = rd_q;
                end
                default: rr_d = RESP_ERR;
            endcase
        end else if (rv_q && i_axi_rready) begin
            rv_d = 1'b0;
        end
    end

    // Sequencer next state and pin values, one cycle behind the state.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        step_d = step_q;
        op_d = op_q;
        rd_d = rd_q;
        err_d = err_q;
        sus_d = sus_q;
        // The window drains on its own; the device erases when it empties.
        win_d = (win_q != '0) ? win_q - 1'b1 : win_q;
        if (refuse) begin
            err_d = 1'b1;
        end else if (accept) begin
            err_d = 1'b0;
        end
        unique case (st_q)
            S_IDLE: begin
                if (accept) begin
                    op_d = cmd_op;
                    // Only full erases send the unlock and set-up cycles.
                    step_d = (cmd_op == OP_CHIP || cmd_op == OP_SECT)
                             ? 3'h0 : LAST_STEP;
                    st_d = S_WSU;
                    if (cmd_op == OP_READ) begin
                        st_d = S_RLO;
                        cnt_d = CNT_W'(RD_CYC + SYNC_N);
                    end else if (cmd_op == OP_RST) begin
                        st_d = S_RST;
                        cnt_d = CNT_W'(RST_CYC);
                    end
                    // Suspend ends the window; chip erase has none.
                    if (cmd_op == OP_SUS || cmd_op == OP_CHIP) begin
                        win_d = '0;
                    end
                    if (cmd_op == OP_SUS) begin
                        sus_d = 1'b1;
                    end
                    if (cmd_op == OP_RES) begin
                        sus_d = 1'b0;
                    end
                end
            end
            S_WSU: begin
                st_d = S_WLO;
                cnt_d = CNT_W'(WP_CYC);
            end
            S_WLO: begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == CNT_W'(1)) begin
                    st_d = S_WHI;
                    cnt_d = CNT_W'(WPH_CYC);
                end
            end
            S_WHI: begin
                // The window restarts at the strobe rise of each sector.
                if (cnt_q == CNT_W'(WPH_CYC) && step_q == LAST_STEP
                    && (op_q == OP_SECT || op_q == OP_ADD)) begin
                    win_d = P_WIN_CYC;
                end
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == CNT_W'(1)) begin
                    st_d = (step_q == LAST_STEP) ? S_IDLE : S_WSU;
                    step_d = step_q + 1'b1;
                end
            end
            S_RLO: begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == CNT_W'(1)) begin
                    rd_d = dqs2_q;
                    st_d = S_IDLE;
                end
            end
            S_RST: begin
                // Reset drops any pending sectors and any suspension.
                win_d = '0;
                sus_d = 1'b0;
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == CNT_W'(1)) begin
                    st_d = S_IDLE;
                end
            end
        endcase
        // Pins follow the present state, so they lag it by one cycle.
        pa_d = (st_q == S_RLO) ? addr_q[21:0] : seq_a;
        pd_d = seq_d;
        poe_d = (st_q == S_WSU || st_q == S_WLO || st_q == S_WHI);
        ce_d = !(poe_d || st_q == S_RLO);
        oe_d = (st_q != S_RLO);
        we_d = (st_q != S_WLO);
        rst_d = (st_q != S_RST);
    end

    // Register every group; reset leaves the flash bus idle and released.
    always_ff @(posedge i_mclk) begin
        dqs1_q <= i_fl_dq;
        dqs2_q <= dqs1_q;
        if (i_sys_rst) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            bv_q <= 1'b0;
            rv_q <= 1'b0;
            awa_q <= '0;
            ws_q <= '0;
            wd_q <= '0;
            br_q <= RESP_OK;
            rr_q <= RESP_OK;
            rd_bus_q <= '0;
            addr_q <= '0;
            err_q <= 1'b0;
            sus_q <= 1'b0;
            win_q <= '0;
            st_q <= S_IDLE;
            cnt_q <= '0;
            step_q <= '0;
            op_q <= '0;
            rd_q <= '0;
            pa_q <= '0;
            pd_q <= '0;
            poe_q <= 1'b0;
            ce_q <= 1'b1;
            oe_q <= 1'b1;
            we_q <= 1'b1;
            rst_q <= 1'b1;
        end else begin
            aw_q <= aw_d;
            w_q <= w_d;
            bv_q <= bv_d;
            rv_q <= rv_d;
            awa_q <= awa_d;
            ws_q <= ws_d;
            wd_q <= wd_d;
            br_q <= br_d;
            rr_q <= rr_d;
            rd_bus_q <= rd_bus_d;
            addr_q <= addr_d;
            err_q <= err_d;
            sus_q <= sus_d;
            win_q <= win_d;
            st_q <= st_d;
            cnt_q <= cnt_d;
            step_q <= step_d;
            op_q <= op_d;
            rd_q <= rd_d;
            pa_q <= pa_d;
            pd_q <= pd_d;
            poe_q <= poe_d;
            ce_q <= ce_d;
            oe_q <= oe_d;
            we_q <= we_d;
            rst_q <= rst_d;
        end
    end

    // Helper for checks: write strobes issued since the last command.
    logic [3:0] nwr_q;
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst || accept) begin
            nwr_q <= '0;
        end else if (we_q && !we_d) begin
            nwr_q <= nwr_q + 1'b1;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    sequence seq_we_low;
        !o_fl_we_n [*5] ##1 o_fl_we_n;
    endsequence
    sequence seq_rst_low;
        !o_fl_rst_n [*8];
    endsequence

    a_chip_six_writes: assert property (
        (st_q == S_WHI && cnt_q == CNT_W'(1) && step_q == LAST_STEP
         && op_q == OP_CHIP) |-> nwr_q == 4'h6)
        else $error("chip erase did not issue six writes");
    a_we_pulse_width: assert property (
        $fell(o_fl_we_n) |-> !o_fl_ce_n throughout seq_we_low)
        else $error("write strobe width wrong");
    a_sect_last_code: assert property (
        (st_q == S_WLO && step_q == LAST_STEP && op_q == OP_SECT)
        |=> (o_fl_dq == CD_SECT && o_fl_addr == addr_q[21:0]))
        else $error("sector erase final cycle wrong");
    a_reset_pulse_held: assert property (
        (accept && cmd_op == OP_RST) |=> ##1 seq_rst_low)
        else $error("hardware reset pulse too short");
    a_late_add_refused: assert property (
        (cmd_go && !busy && cmd_op == OP_ADD && win_q == '0)
        |=> (err_q && st_q == S_IDLE))
        else $error("sector added after window closed");
    a_window_restart: assert property (
        ($rose(o_fl_we_n) && step_q == LAST_STEP && op_q == OP_SECT)
        |-> win_q == P_WIN_CYC)
        else $error("window not restarted at strobe rise");
    a_suspend_ends_win: assert property (
        (accept && cmd_op == OP_SUS) |=> (win_q == '0 && sus_q))
        else $error("suspend did not end window");
    a_resume_code: assert property (
        (st_q == S_WLO && op_q == OP_RES) |=> o_fl_dq == CD_RES)
        else $error("resume code wrong");
    a_unlock_first: assert property (
        (st_q == S_WLO && step_q == 3'h0)
        |=> (o_fl_addr == UNLK_A1 && o_fl_dq == CD_UNLK1))
        else $error("first unlock cycle wrong");
endmodule // fles_host

// >>> tb/fles_flash_model.sv
// Behavioural flash device that answers the erase sequencer's pins.
`timescale 1ns/10ps
module fles_flash_model #(
    parameter int WIN_NS   = 600,
    parameter int ERASE_NS = 3000
) (
    input  wire logic [21:0] i_addr,
    input  wire logic [15:0] i_dq,
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic        i_rst_n,
    output logic [15:0]      o_dq
);
    // Mode: 0 read, 1 chip erase, 2 window, 3 sector erase, 4 suspended.
    int          mode = 0;
    int          step = 0;
    time         t_w  = 0;
    time         t_e  = 0;
    logic [6:0]  sect[$];
    logic        tog  = 1'b0;
    logic [15:0] last = 16'h0000;
    logic [15:0] drv;
    logic [10:0] a;
    logic [7:0]  d;
    logic [10:0] ua[5] = '{11'h555, 11'h2aa, 11'h555, 11'h555, 11'h2aa};
    logic [7:0]  ud[5] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55};

    // Sector membership by the upper address bits only.
    function automatic logic in_sect(input logic [21:0] x);
        foreach (sect[i]) if (sect[i] == x[21:15]) return 1'b1;
        return 1'b0;
    endfunction

    // Window expiry starts the erase; erase completion returns to read.
    always #20 begin
        if (mode == 2 && $time - t_w >= WIN_NS) begin
            mode = 3;
            t_e = $time;
        end
        if ((mode == 1 || mode == 3) && $time - t_e >= ERASE_NS) begin
            mode = 0;
            sect.delete();
        end
    end

    // Commands are taken at the rising write strobe, low bits only.
    always @(posedge i_we_n) if (!i_ce_n && i_rst_n) begin
        a = i_addr[10:0];
        d = i_dq[7:0];
        if (mode == 1) begin
            step = 0;
        end else if (mode == 3) begin
            if (d == 8'hb0) mode = 4;
        end else if (mode == 2 && d == 8'h30) begin
            sect.push_back(i_addr[21:15]);
            t_w = $time;
        end else if (mode == 2) begin
            mode = (d == 8'hb0) ? 4 : 0;
            if (mode == 0) sect.delete();
        end else if (mode == 4 && step == 0 && d == 8'h30) begin
            mode = 3;
            t_e = $time;
        end else if (step < 5) begin
            step = (a == ua[step] && d == ud[step]) ? step + 1 : 0;
        end else begin
            // A new erase is taken only in read mode, not while busy or suspended.
            step = 0;
            if (mode == 0 && a == 11'h555 && d == 8'h10) begin
                mode = 1;
                t_e = $time;
            end else if (mode == 0 && d == 8'h30) begin
                mode = 2;
                t_w = $time;
                sect.push_back(i_addr[21:15]);
            end
        end
    end

    // Hardware reset aborts any erase at once.
    always @(negedge i_rst_n) begin
        mode = 0;
        step = 0;
        sect.delete();
    end

    // Status on suspended sectors, and at every address in modes 1 to 3; array data elsewhere.
    // The host never programs, so suspended read is left only by resume or hardware reset.
    always @* begin
        if (mode == 4 && in_sect(i_addr)) drv = {8'h00, 4'h8, 1'b1, tog,
            2'b00};
        else if (mode != 0 && mode != 4) drv = {8'h00, 1'b0, tog, 2'b00,
            (mode != 2), tog, 2'b00};
        else drv = i_addr[15:0] ^ 16'ha5c3;
    end

    // A released bus shows the inverse, never a stale value.
    assign o_dq = (!i_ce_n && !i_oe_n) ? drv : ~last;

    always @(posedge i_oe_n) begin
        last = drv;
        tog = ~tog;
    end
endmodule // fles_flash_model

// >>> tb/tb_flash_erase_sequencer.sv
// Self-checking bench for the erase sequencer host and its flash model.
`timescale 1ns/10ps
module tb_flash_erase_sequencer;
    import fles_pkg::*;
    logic        i_mclk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, strb = 4'hf;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic        dq_oe, ce_n, oe_n, we_n, fl_rst_n;
    logic [1:0]  bresp, rresp, rs;
    logic [31:0] rdata, rv, st;
    logic [21:0] fl_addr, sa, ta;
    logic [15:0] fl_dq, m_dq, fl_bus, fd;
    logic [29:0] wq[$];
    int          error_cnt = 0, comparisons = 0, seed = 64995, rst_lo = 0;

    assign fl_bus = dq_oe ? fl_dq : m_dq;

    fles_host #(.P_WIN_CYC(16'h0028)) i_fles_host (
        .i_mclk, .i_sys_rst, .i_axi_awaddr(awaddr),
        .i_axi_awvalid(awvalid), .o_axi_awready(awready),
        .i_axi_wdata(wdata), .i_axi_wstrb(wstrb), .i_axi_wvalid(wvalid),
        .o_axi_wready(wready), .o_axi_bresp(bresp), .o_axi_bvalid(bvalid),
        .i_axi_bready(bready), .i_axi_araddr(araddr),
        .i_axi_arvalid(arvalid), .o_axi_arready(arready),
        .o_axi_rdata(rdata), .o_axi_rresp(rresp), .o_axi_rvalid(rvalid),
        .i_axi_rready(rready), .o_fl_addr(fl_addr), .o_fl_dq(fl_dq),
        .o_fl_dq_oe(dq_oe), .i_fl_dq(fl_bus), .o_fl_ce_n(ce_n),
        .o_fl_oe_n(oe_n), .o_fl_we_n(we_n), .o_fl_rst_n(fl_rst_n));

    fles_flash_model #(.WIN_NS(600), .ERASE_NS(3000)) i_fles_flash_model (
        .i_addr(fl_addr), .i_dq(fl_dq), .i_ce_n(ce_n), .i_oe_n(oe_n),
        .i_we_n(we_n), .i_rst_n(fl_rst_n), .o_dq(m_dq));

    initial begin
        forever #4 i_mclk = ~i_mclk;
    end

    // Log every flash write and count reset-low cycles.
    always @(posedge we_n) if (ce_n === 1'b0) wq.push_back({fl_addr,
        fl_dq[7:0]});
    always @(posedge i_mclk) if (fl_rst_n === 1'b0) rst_lo++;

    function automatic logic [15:0] arr(input logic [21:0] x);
        return x[15:0] ^ 16'ha5c3;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", n, e, g);
        end
    endtask

    // One write; address and data released as each is taken.
    task automatic axw(input logic [3:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        @(posedge i_mclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= strb;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge i_mclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axr(input logic [3:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge i_mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge i_mclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // Issue an op, then poll status until the host is idle.
    task automatic run(input logic [2:0] c, output logic [31:0] s);
        axw(REG_CTRL, {29'h0, c}, rs);
        chk("ctrl bresp", 32'(RESP_OK), 32'(rs));
        do axr(REG_STAT, s, rs); while (s[STAT_BUSY] !== 1'b0);
    endtask

    task automatic rd_fl(input logic [21:0] a, output logic [15:0] d);
        logic [31:0] s;
        axw(REG_ADDR, {10'h000, a}, rs);
        run(OP_READ, s);
        d = s[31:16];
    endtask

    task automatic chk_seq(input logic [2:0] c, input logic [21:0] a);
        logic [29:0] e[$];
        e = '{};
        if (c == OP_CHIP || c == OP_SECT)
            e = '{{UNLK_A1, CD_UNLK1[7:0]}, {UNLK_A2, CD_UNLK2[7:0]},
                  {UNLK_A1, CD_SETUP[7:0]}, {UNLK_A1, CD_UNLK1[7:0]},
                  {UNLK_A2, CD_UNLK2[7:0]}};
        if (c == OP_CHIP) e.push_back({UNLK_A1, CD_CHIP[7:0]});
        if (c == OP_SECT || c == OP_ADD) e.push_back({a, CD_SECT[7:0]});
        if (c == OP_SUS) e.push_back({ANY_A, CD_SUS[7:0]});
        if (c == OP_RES) e.push_back({ANY_A, CD_RES[7:0]});
        chk("write count", e.size(), wq.size());
        foreach (e[i]) chk("flash write", e[i], wq[i]);
        wq = '{};
    endtask

    task automatic conclude();
        $display("comparisons %0d, errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge i_mclk);
        error_cnt++;
        conclude();
    end

    initial begin
        repeat (5) @(posedge i_mclk);
        i_sys_rst <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            axr(4'(i * 4), rv, rs);
            chk("reset value", 32'h0000_0000, rv);
        end
        axr(4'hc, rv, rs);
        chk("unmapped rresp", 32'(RESP_ERR), 32'(rs));
        axw(4'hc, 32'h0000_0001, rs);
        chk("unmapped bresp", 32'(RESP_ERR), 32'(rs));
        rv = $random(seed);
        axw(REG_ADDR, rv, rs);
        axr(REG_ADDR, st, rs);
        chk("address readback", rv, st);
        // Only the lowest byte lane may change under a partial strobe.
        strb = 4'h1;
        axw(REG_ADDR, ~rv, rs);
        strb = 4'hf;
        axr(REG_ADDR, st, rs);
        chk("byte strobe", {rv[31:8], ~rv[7:0]}, st);
        repeat (3) begin
            ta = 22'($random(seed));
            rd_fl(ta, fd);
            chk("array read", arr(ta), fd);
        end
        axw(REG_CTRL, 32'h0000_0000, rs);
        axr(REG_STAT, st, rs);
        chk("op zero", 32'h0000_0002, {16'h0000, st[15:0]});
        chk("op zero writes", 32'h0000_0000, wq.size());
        // Chip erase with a refused command while the host is busy.
        axw(REG_CTRL, 32'(OP_CHIP), rs);
        run(OP_SECT, st);
        chk("busy refusal", 32'h1, st[STAT_ERR]);
        chk_seq(OP_CHIP, ANY_A);
        rd_fl(ta, fd);
        chk("chip poll bit", 32'h0, fd[7]);
        repeat (500) @(posedge i_mclk);
        rd_fl(ta, fd);
        chk("after erase", arr(ta), fd);
        // Sector erase, added sector, suspend and resume.
        sa = 22'($random(seed));
        axw(REG_ADDR, 32'(sa), rs);
        run(OP_SECT, st);
        chk("window open", 32'h1, st[STAT_WIN]);
        chk_seq(OP_SECT, sa);
        axw(REG_ADDR, 32'(sa ^ 22'h20_0000), rs);
        run(OP_ADD, st);
        chk_seq(OP_ADD, sa ^ 22'h20_0000);
        run(OP_SUS, st);
        chk("suspended", 32'h1, st[STAT_SUS]);
        chk_seq(OP_SUS, ANY_A);
        rd_fl(sa, fd);
        chk("suspended sector", 32'h2, fd[7:6]);
        rd_fl(sa ^ 22'h10_0000, fd);
        chk("other sector", arr(sa ^ 22'h10_0000), fd);
        run(OP_RES, st);
        chk("resumed", 32'h0, st[STAT_SUS]);
        chk_seq(OP_RES, ANY_A);
        repeat (50) @(posedge i_mclk);
        run(OP_ADD, st);
        chk("late add", 32'h1, st[2:1]);
        chk("late add writes", 32'h0, wq.size());
        rd_fl(sa, fd);
        chk("erasing poll bit", 32'h0, fd[7]);
        rst_lo = 0;
        run(OP_RST, st);
        chk("reset pulse", RST_CYC, rst_lo);
        rd_fl(sa, fd);
        chk("after reset", arr(sa), fd);
        conclude();
    end
endmodule // tb_flash_erase_sequencer
